// *** hdl/ushrt_top.sv ***
// shadow alias of the receive buffer and transmit holding register
`timescale 1ns/1ps
module ushrt_top (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [31:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic RX_VALID,
  input wire logic [7:0] RX_SERIAL_BYTE,
  input wire logic [7:0] RX_IR_BYTE,
  input wire logic TX_TAKE,
  output logic TX_VALID,
  output logic [7:0] TX_SERIAL_BYTE,
  output logic [7:0] TX_IR_BYTE_N,
  output logic IR_MODE,
  output logic IRQ
);
  logic [1:0] ctrl, next_ctrl;
  logic [2:0] ev, next_ev;
  logic [2:0] ev_en, next_ev_en;
  logic overrun, next_overrun;
  logic [31:0] rdata, next_rdata;
  logic tx_valid, next_tx_valid;
  logic [7:0] tx_ser, next_tx_ser;
  logic [7:0] tx_ir, next_tx_ir;
  logic irq, next_irq;
  logic ir_mode_q, next_ir_mode_q;
  logic fifo_en, ir_mode;
  logic sh_hit, rd_sh, wr_sh;
  logic [7:0] rx_byte, rx_head, tx_head;
  logic rx_empty, rx_full, rx_drop, tx_empty, tx_full, tx_drop;
  logic rx_over_wr, tx_pop;

  // ****************************************
  // address decode
  // ****************************************
  function automatic logic is_shadow(input logic [31:0] a);
    logic [31:0] off;
    off = a - ushrt_pkg::USHRT_SHADOW_BASE;
    is_shadow = (a >= ushrt_pkg::USHRT_SHADOW_BASE) &&
                (off < ushrt_pkg::USHRT_SHADOW_SPAN) && (a[1:0] == 2'h0);
  endfunction

  always_comb
  begin
    fifo_en = ctrl[ushrt_pkg::USHRT_CTRL_FIFO_EN];
    ir_mode = ctrl[ushrt_pkg::USHRT_CTRL_IR_MODE];
    sh_hit = is_shadow(ADDR);
    rd_sh = RD && sh_hit;
    wr_sh = WR && sh_hit;
    rx_byte = ir_mode ? RX_IR_BYTE : RX_SERIAL_BYTE;
    tx_pop = tx_valid && TX_TAKE;
    rx_over_wr = RX_VALID && !fifo_en && rx_full && !rd_sh;
  end

  // ****************************************
  // receive and transmit queues
  // ****************************************
  ushrt_fifo u_rx (
    .clk(CLK),
    .rst(RST),
    .fifo_en(fifo_en),
    .push(RX_VALID),
    .push_data(rx_byte),
    .pop(rd_sh),
    .head(rx_head),
    .empty(rx_empty),
    .full(rx_full),
    .dropped(rx_drop)
  );

  ushrt_fifo u_tx (
    .clk(CLK),
    .rst(RST),
    .fifo_en(fifo_en),
    .push(wr_sh),
    .push_data(WDATA[7:0]),
    .pop(tx_pop),
    .head(tx_head),
    .empty(tx_empty),
    .full(tx_full),
    .dropped(tx_drop)
  );

  // ****************************************
  // registers and outputs
  // ****************************************
  always_comb
  begin
    next_ctrl = ctrl;
    next_ev_en = ev_en;
    next_ev = ev;
    next_overrun = overrun;
    next_rdata = 32'h0000_0000;
    if (RD && ADDR == ushrt_pkg::USHRT_STATUS)
    begin
      next_overrun = 1'b0;
    end
    if (WR && ADDR == ushrt_pkg::USHRT_CTRL)
    begin
      next_ctrl = WDATA[1:0];
    end
    else if (WR && ADDR == ushrt_pkg::USHRT_IRQ_CLR)
    begin
      next_ev = ev & ~WDATA[2:0];
    end
    else if (WR && ADDR == ushrt_pkg::USHRT_IRQ_EN)
    begin
      next_ev_en = WDATA[2:0];
    end
    if (rx_over_wr || rx_drop)
    begin
      next_overrun = 1'b1;
      next_ev[ushrt_pkg::USHRT_EV_OVR] = 1'b1;
    end
    if (RX_VALID)
    begin
      next_ev[ushrt_pkg::USHRT_EV_RX] = 1'b1;
    end
    if (tx_pop && tx_empty == 1'b0 && !wr_sh)
    begin
      next_ev[ushrt_pkg::USHRT_EV_TXE] = 1'b1;
    end
    if (rd_sh)
    begin
      // only bits 7:0 carry data; upper bits zero
      next_rdata = {24'h00_0000, rx_empty ? 8'h00 : rx_head};
    end
    else if (RD && ADDR == ushrt_pkg::USHRT_CTRL)
    begin
      next_rdata = {30'h0000_0000, ctrl};
    end
    else if (RD && ADDR == ushrt_pkg::USHRT_STATUS)
    begin
      next_rdata = 32'h0000_0000;
      next_rdata[ushrt_pkg::USHRT_ST_DATA_READY] = !rx_empty;
      next_rdata[ushrt_pkg::USHRT_ST_OVR] = overrun;
      next_rdata[ushrt_pkg::USHRT_ST_HOLD_EMPTY] = tx_empty;
      next_rdata[10:8] = ev;
    end
    else if (RD && ADDR == ushrt_pkg::USHRT_IRQ_EN)
    begin
      next_rdata = {29'h0000_0000, ev_en};
    end
    next_irq = |(next_ev & next_ev_en);
    next_tx_valid = !tx_empty && !tx_pop;
    next_tx_ser = tx_head;
    next_tx_ir = ~tx_head;
    next_ir_mode_q = ir_mode;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      ctrl <= ushrt_pkg::USHRT_CTRL_RESET;
      ev <= ushrt_pkg::USHRT_EV_RESET;
      ev_en <= ushrt_pkg::USHRT_EV_RESET;
      overrun <= 1'b0;
      rdata <= 32'h0000_0000;
      tx_valid <= 1'b0;
      tx_ser <= ushrt_pkg::USHRT_BYTE_RESET;
      tx_ir <= ~ushrt_pkg::USHRT_BYTE_RESET;
      irq <= 1'b0;
      ir_mode_q <= 1'b0;
    end
    else
    begin
      ctrl <= next_ctrl;
      ev <= next_ev;
      ev_en <= next_ev_en;
      overrun <= next_overrun;
      rdata <= next_rdata;
      tx_valid <= next_tx_valid;
      tx_ser <= next_tx_ser;
      tx_ir <= next_tx_ir;
      irq <= next_irq;
      ir_mode_q <= next_ir_mode_q;
    end
  end

  always_comb
  begin
    RDATA = rdata;
    TX_VALID = tx_valid;
    TX_SERIAL_BYTE = tx_ser;
    TX_IR_BYTE_N = tx_ir;
    IR_MODE = ir_mode_q;
    IRQ = irq;
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_shadow_read;
    RD && is_shadow(ADDR);
  endsequence

  a_upper_zero: assert property (@(posedge CLK) disable iff (RST)
    s_shadow_read |=> RDATA[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  a_overrun_flag: assert property (@(posedge CLK) disable iff (RST)
    (rx_over_wr || rx_drop) |=> overrun)
    else $error("overrun not flagged");
  a_rx_drop_keep: assert property (@(posedge CLK) disable iff (RST)
    rx_drop |=> $stable(rx_head) && rx_full)
    else $error("full receive fifo changed");
  a_tx_drop_keep: assert property (@(posedge CLK) disable iff (RST)
    tx_drop |=> tx_full)
    else $error("full transmit fifo lost state");
  a_hold_empty_clr: assert property (@(posedge CLK) disable iff (RST)
    (wr_sh && tx_empty && !fifo_en) |=> !tx_empty)
    else $error("holding empty not cleared");
  a_rx_read_head: assert property (@(posedge CLK) disable iff (RST)
    (s_shadow_read and !rx_empty) |=> RDATA[7:0] == $past(rx_head))
    else $error("read not fifo head");
  a_irq_level: assert property (@(posedge CLK) disable iff (RST)
    IRQ == $past(|(next_ev & next_ev_en)))
    else $error("interrupt level wrong");
  a_ir_invert: assert property (@(posedge CLK) disable iff (RST)
    TX_IR_BYTE_N == ~TX_SERIAL_BYTE)
    else $error("infrared byte not inverted");
endmodule

// *** hdl/ushrt_pkg.sv ***
// constants for the shadow receive/transmit holding block
//
// Contract
// - sixteen 32-bit word locations all alias one receive and transmit byte.
// - reads return received byte in bits 7:0, serial or infrared input.
// - read data valid only while the data-ready flag is set.
// - fifos off: unread byte overwritten by the next, overrun flagged.
// - fifos on: a read returns the receive fifo head.
// - receive fifo full: new character dropped, contents kept, overrun flagged.
// - a write supplies a byte for serial or active-low infrared output.
// - fifos off and holding empty: one write clears holding empty.
// - fifos off: further writes before empty sets overwrite pending byte.
// - fifos on: accept writes up to transmit fifo depth, 16.
// - fifos on: a write while the transmit fifo is full is discarded.
package ushrt_pkg;
  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [31:0] USHRT_SHADOW_BASE = 32'h5000_1030;
  localparam logic [31:0] USHRT_SHADOW_14 = 32'h5000_1068;
  localparam logic [31:0] USHRT_SHADOW_15 = 32'h5000_106c;
  localparam logic [31:0] USHRT_CTRL = 32'h5000_1200;
  localparam logic [31:0] USHRT_STATUS = 32'h5000_1204;
  localparam logic [31:0] USHRT_IRQ_CLR = 32'h5000_1208;
  localparam logic [31:0] USHRT_IRQ_EN = 32'h5000_120c;
  localparam logic [31:0] USHRT_SHADOW_SPAN = 32'h0000_0040;
  // ****************************************
  // fields
  // ****************************************
  localparam int USHRT_CTRL_FIFO_EN = 0;
  localparam int USHRT_CTRL_IR_MODE = 1;
  localparam int USHRT_ST_DATA_READY = 0;
  localparam int USHRT_ST_OVR = 1;
  localparam int USHRT_ST_HOLD_EMPTY = 5;
  localparam int USHRT_EV_RX = 0;
  localparam int USHRT_EV_OVR = 1;
  localparam int USHRT_EV_TXE = 2;
  localparam logic [2:0] USHRT_EV_RESET = 3'h0;
  localparam logic [1:0] USHRT_CTRL_RESET = 2'h0;
  localparam logic [7:0] USHRT_BYTE_RESET = 8'h00;
  // ****************************************
  // fifo sizing
  // ****************************************
  localparam int USHRT_DEPTH = 16;
  localparam int USHRT_AW = 4;
  localparam logic [4:0] USHRT_DEPTH_CNT = 5'h10;
  localparam logic [4:0] USHRT_ONE = 5'h01;
  localparam logic [4:0] USHRT_ZERO = 5'h00;
endpackage

// *** hdl/ushrt_fifo.sv ***
// byte fifo with bypass single-entry mode, used for receive and transmit
`timescale 1ns/1ps
module ushrt_fifo (
  input wire logic clk,
  input wire logic rst,
  input wire logic fifo_en,
  input wire logic push,
  input wire logic [7:0] push_data,
  input wire logic pop,
  output logic [7:0] head,
  output logic empty,
  output logic full,
  output logic dropped
);
  logic [7:0] mem [ushrt_pkg::USHRT_DEPTH];
  logic [ushrt_pkg::USHRT_AW-1:0] rd_ptr, next_rd_ptr;
  logic [ushrt_pkg::USHRT_AW-1:0] wr_ptr, next_wr_ptr;
  logic [4:0] count, next_count;
  logic do_push, do_pop, overwrite;
  // ****************************************
  // capacity 1 when fifos are off; otherwise depth
  // ****************************************
  always_comb
  begin
    full = fifo_en ? (count == ushrt_pkg::USHRT_DEPTH_CNT)
                   : (count == ushrt_pkg::USHRT_ONE);
    empty = (count == ushrt_pkg::USHRT_ZERO);
    head = mem[rd_ptr];
    do_pop = pop && !empty;
    overwrite = push && !fifo_en && full && !do_pop;
    do_push = push && (!full || do_pop) && !overwrite;
    dropped = push && fifo_en && full && !do_pop;
    next_rd_ptr = do_pop ? rd_ptr + 1'b1 : rd_ptr;
    next_wr_ptr = do_push ? wr_ptr + 1'b1 : wr_ptr;
    next_count = count;
    if (do_push && !do_pop)
    begin
      next_count = count + ushrt_pkg::USHRT_ONE;
    end
    else if (do_pop && !do_push)
    begin
      next_count = count - ushrt_pkg::USHRT_ONE;
    end
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count <= ushrt_pkg::USHRT_ZERO;
    end
    else
    begin
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      count <= next_count;
    end
  end
  // overwrite replaces the single pending byte in place
  always_ff @(posedge clk)
  begin
    if (do_push)
    begin
      mem[wr_ptr] <= push_data;
    end
    else if (overwrite)
    begin
      mem[rd_ptr] <= push_data;
    end
  end
endmodule

// *** dv/ushrt_partner.sv ***
// far-side serial engine model: delivers received bytes, takes sent ones
`timescale 1ns/1ps
module ushrt_partner (
  input wire logic clk,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  output logic tx_take,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic [7:0] rx_ir_byte
);
  logic take_en = 1'b0;
  logic [7:0] got[$];
  initial
  begin
    tx_take = 1'b0;
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    rx_ir_byte = 8'hff;
  end
  // one received byte; lines show the inverse once released
  task automatic send(input logic [7:0] b);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_byte <= b;
    rx_ir_byte <= b ^ 8'ha5;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_byte <= ~b;
    rx_ir_byte <= ~(b ^ 8'ha5);
  endtask
  // takes a pending byte only while allowed, so the bench can stall
  always @(posedge clk)
  begin
    tx_take <= take_en & tx_valid & ~tx_take;
    if (tx_take & tx_valid)
      got.push_back(tx_byte);
  end
endmodule

// *** dv/ushrt_top_tb.sv ***
// self-checking bench for the shadow receive/transmit holding block
`timescale 1ns/1ps
module ushrt_top_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] addr = 32'h0000_0000;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [31:0] rdata;
  logic rx_valid, tx_take, tx_valid, ir_mode, irq;
  logic [7:0] rx_byte, rx_ir, tx_byte, tx_ir_n;
  logic [31:0] d;
  int errors = 0;
  int num_checks = 0;
  always #2 clk = ~clk;
  ushrt_top uut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata),
    .WR(wr_s), .RD(rd_s), .RDATA(rdata), .RX_VALID(rx_valid),
    .RX_SERIAL_BYTE(rx_byte), .RX_IR_BYTE(rx_ir), .TX_TAKE(tx_take),
    .TX_VALID(tx_valid), .TX_SERIAL_BYTE(tx_byte),
    .TX_IR_BYTE_N(tx_ir_n), .IR_MODE(ir_mode), .IRQ(irq));
  ushrt_partner far (.clk(clk), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .tx_take(tx_take), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .rx_ir_byte(rx_ir));
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge clk);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr_s <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic st;
    rd(ushrt_pkg::USHRT_STATUS);
  endtask
  task automatic do_reset;
    rst <= 1'b1;
    far.take_en = 1'b0;
    far.got.delete();
    repeat (16) @(posedge clk);
    rst <= 1'b0;
  endtask
  // lets the partner take bytes until nothing is pending
  task automatic drain;
    int idle;
    idle = 0;
    far.take_en = 1'b1;
    for (int i = 0; i < 200 && idle < 3; i++)
    begin
      @(posedge clk);
      #1;
      idle = tx_valid ? 0 : idle + 1;
    end
    if (idle < 3)
    begin
      errors++;
      end_sim;
    end
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_rx_off;
    do_reset;
    st;
    chk(d & 32'h0000_0020, 32'h0000_0020);
    far.send(8'h11);
    far.send(8'h22);
    st;
    chk(d & 32'h0000_0003, 32'h0000_0003);
    rd(ushrt_pkg::USHRT_SHADOW_14);
    chk(d, 32'h0000_0022);
    st;
    chk(d & 32'h0000_0001, 32'h0000_0000);
    wr(ushrt_pkg::USHRT_CTRL, 32'h0000_0002);
    far.send(8'h3c);
    rd(ushrt_pkg::USHRT_SHADOW_15);
    chk(d, 32'h0000_0099);
    chk({31'h0, ir_mode}, 32'h0000_0001);
    $display("test rx_off done");
  endtask
  task automatic t_rx_fifo;
    do_reset;
    wr(ushrt_pkg::USHRT_CTRL, 32'h0000_0001);
    for (int i = 0; i < 17; i++)
      far.send(8'h40 + 8'(i));
    st;
    chk(d & 32'h0000_0002, 32'h0000_0002);
    for (int i = 0; i < 16; i++)
    begin
      rd(ushrt_pkg::USHRT_SHADOW_BASE + 32'(4 * i));
      chk(d, 32'h0000_0040 + 32'(i));
    end
    st;
    chk(d & 32'h0000_0001, 32'h0000_0000);
    $display("test rx_fifo done");
  endtask
  task automatic t_tx_off;
    do_reset;
    wr(ushrt_pkg::USHRT_CTRL, 32'h0000_0002);
    wr(ushrt_pkg::USHRT_SHADOW_14, 32'h0000_ff41);
    @(posedge clk);
    #1 chk({tx_valid, tx_byte, tx_ir_n}, {15'h0, 17'h1_41be});
    st;
    chk(d & 32'h0000_0020, 32'h0000_0000);
    wr(ushrt_pkg::USHRT_SHADOW_15, 32'h0000_0042);
    @(posedge clk);
    #1 chk({24'h0, tx_byte}, 32'h0000_0042);
    drain;
    chk(32'(far.got.size()), 32'h0000_0001);
    chk({24'h0, far.got[0]}, 32'h0000_0042);
    wr(32'h5000_1070, 32'h0000_0055);
    repeat (2) @(posedge clk);
    #1 chk({31'h0, tx_valid}, 32'h0000_0000);
    $display("test tx_off done");
  endtask
  task automatic t_tx_fifo;
    do_reset;
    wr(ushrt_pkg::USHRT_CTRL, 32'h0000_0001);
    st;
    chk(d & 32'h0000_0020, 32'h0000_0020);
    for (int i = 0; i < 17; i++)
      wr(ushrt_pkg::USHRT_SHADOW_BASE + 32'(4 * (i % 16)), 32'h60 + i);
    drain;
    chk(32'(far.got.size()), 32'h0000_0010);
    for (int i = 0; i < 16; i++)
      chk({24'h0, far.got[i]}, 32'h0000_0060 + 32'(i));
    $display("test tx_fifo done");
  endtask
  task automatic t_irq;
    do_reset;
    far.send(8'h77);
    repeat (2) @(posedge clk);
    #1 chk({31'h0, irq}, 32'h0000_0000);
    wr(ushrt_pkg::USHRT_IRQ_EN, 32'h0000_0001);
    repeat (2) @(posedge clk);
    #1 chk({31'h0, irq}, 32'h0000_0001);
    wr(ushrt_pkg::USHRT_IRQ_CLR, 32'h0000_0001);
    repeat (2) @(posedge clk);
    #1 chk({31'h0, irq}, 32'h0000_0000);
    st;
    chk(d & 32'h0000_0100, 32'h0000_0000);
    $display("test irq done");
  endtask
  initial
  begin
    t_rx_off;
    t_rx_fifo;
    t_tx_off;
    t_tx_fifo;
    t_irq;
    end_sim;
  end
endmodule
